// ===== verilog/dgc_defs.svh
// register offsets, field positions, reset values and timing counts
`ifndef DGC_DEFS_SVH
`define DGC_DEFS_SVH

// register offsets (read address; writes add the write flag)
`define DGC_ADDR_GLOBAL_CONFIGURATION    7'h00
`define DGC_ADDR_GFLAGS   7'h01
`define DGC_ADDR_WCOUNT   7'h02
`define DGC_ADDR_REPLYCFG 7'h03
`define DGC_WRITE_FLAG    8'h80
`define DGC_WRITE_BIT     7

// global_configuration field positions
`define DGC_GC_SCALE_ANALOG 0
`define DGC_GC_INT_SENSE    1
`define DGC_GC_CHOP_MODE    2
`define DGC_GC_SHAFT        3
`define DGC_GC_MARK_PREWARN 4
`define DGC_GC_MARK_STEP    5
`define DGC_GC_PD_DISABLE   6
`define DGC_GC_MSTEP_REG    7
`define DGC_GC_STEP_FILT    8
`define DGC_GC_TEST_MODE    9

// global_flags field positions
`define DGC_GF_RESET 0
`define DGC_GF_DRV   1
`define DGC_GF_UV    2

// widths and reset values
`define DGC_GLOBAL_CONFIGURATION_W     10
`define DGC_GFLAGS_W    3
`define DGC_WCOUNT_W    8
`define DGC_DELAY_W     4
`define DGC_GLOBAL_CONFIGURATION_RST   10'h101
`define DGC_GFLAGS_RST  2'h1
`define DGC_WCOUNT_RST  8'h00
`define DGC_DELAY_RST   4'h0

// reply delay: bit times per delay unit (two units per step pair), counter width
`define DGC_BITS_PER_UNIT 7'h08
`define DGC_BITCNT_W      7

`endif

// ===== verilog/dgc_pkg.sv
// types and helpers shared by the general configuration register bank
`include "dgc_defs.svh"

package dgc_pkg;

    // one decoded serial frame: address byte and data word
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] data;
    } dgc_req_t;

    // reply handed back to the serial transmitter
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] data;
    } dgc_reply_t;

    // reply delay timer states, gray along idle -> wait
    typedef enum logic [1:0] {
        DGC_IDLE = 2'b00,
        DGC_WAIT = 2'b01
    } dgc_tstate_t;

    // bit times before a reply: 0,1 -> 8; each further pair adds 16
    function automatic logic [6:0] dgc_reply_bits(input logic [3:0] d);
        dgc_reply_bits = {3'b000, d[3:1], 1'b0} * `DGC_BITS_PER_UNIT + `DGC_BITS_PER_UNIT;
    endfunction

endpackage

// ===== verilog/dgc_reply_timer.sv
// reply delay timer: counts bit times before a read reply is released
`timescale 1ns/1ps
`include "dgc_defs.svh"

module dgc_reply_timer (
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic                     start,
    input  wire logic [`DGC_DELAY_W-1:0]  delay,
    input  wire logic                     bit_tick,
    output logic                          done
);
    import dgc_pkg::*;

    dgc_tstate_t              state_r;
    dgc_tstate_t              state_nxt;
    logic [`DGC_BITCNT_W-1:0] cnt_r;
    logic [`DGC_BITCNT_W-1:0] cnt_nxt;
    logic                     done_r;
    logic                     done_nxt;

    // load the bit count on start, count down on each bit tick
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        done_nxt  = 1'b0;
        case (state_r)
            DGC_IDLE: begin
                if (start) begin
                    cnt_nxt   = dgc_reply_bits(delay); // RULE14
                    state_nxt = DGC_WAIT;
                end
            end
            DGC_WAIT: begin
                if (bit_tick) begin
                    cnt_nxt = cnt_r - 7'h01;
                    if (cnt_r == 7'h01) begin
                        done_nxt  = 1'b1; // RULE14
                        state_nxt = DGC_IDLE;
                    end
                end
            end
            default: state_nxt = DGC_IDLE;
        endcase
    end

    // register timer state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= DGC_IDLE;
            cnt_r   <= 7'h00;
            done_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            done_r  <= done_nxt;
        end
    end

    assign done = done_r;

endmodule // dgc_reply_timer

// ===== verilog/dgc_regs.sv
// general configuration and status register bank of the stepper driver
`timescale 1ns/1ps
`include "dgc_defs.svh"

// Behaviour
// RULE1: prewarning select set puts overtemperature prewarning on the marker output.
// RULE2: marker step bit makes marker toggle per internal step; else prewarning select rules.
// RULE3: power-down pin drives standstill reduction only while its disable bit is zero.
// RULE4: a host using the serial interface sets the power-down pin disable bit.
// RULE5: microstep source bit picks resolution pins (zero) or microstep register (one).
// RULE6: step filter bit, reset one, enables step optimization and filtered period readback.
// RULE7: analog test bit routes probe to enable pin, pull-down off, driver enabled.
// RULE8: writing one to a global flag clears it; zero leaves it unchanged.
// RULE9: reset flag is set after any reset and held until host clears it.
// RULE10: driver error flag set on shutdown; clear fails while an error remains active.
// RULE11: undervoltage flag mirrors charge pump undervoltage live and disables the driver.
// RULE12: 8-bit write counter counts each good serial write, reads leave it alone.
// RULE13: write counter wraps from 255 to 0.
// RULE14: read reply waits 8 bit times for delay 0,1, plus 16 per pair up.
// RULE15: write frames carry address plus 0x80, reads the plain address.
// RULE16: registers power up at zero unless another default is given.
// RULE17: with prewarning select zero the marker shows first microstep position.
// RULE18: unimplemented bits read zero and ignore writes.
module dgc_regs (
    input  wire logic                SYS_CLK,
    input  wire logic                RST,
    input  wire logic                FRAME_VALID,
    input  wire dgc_pkg::dgc_req_t   FRAME_REQ,
    input  wire logic                BIT_TICK,
    input  wire logic                STEP_EVENT,
    input  wire logic                MSTEP_FIRST_POS,
    input  wire logic                OT_PREWARN,
    input  wire logic                DRV_SHUTDOWN,
    input  wire logic                DRV_ERR_ACTIVE,
    input  wire logic                PUMP_UNDERVOLTAGE,
    input  wire logic                PDN_PIN,
    input  wire logic                ENABLE_LOW_PIN,
    input  wire logic                RESOLUTION_PIN_A,
    input  wire logic                RESOLUTION_PIN_B,
    output logic                     INDEX_OUT,
    output logic                     STANDSTILL_REDUCE,
    output logic                     MSTEP_FROM_REG,
    output logic [1:0]               RES_PINS,
    output logic                     STEP_FILTER_EN,
    output logic                     TEST_PROBE_EN,
    output logic                     ENABLE_PULLDOWN_OFF,
    output logic                     DRIVER_ENABLE,
    output logic [3:0]               GLOBAL_CONFIGURATION_LOW,
    output logic                     REPLY_VALID,
    output dgc_pkg::dgc_reply_t      REPLY
);
    import dgc_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    localparam int NSYNC = 7;
    logic [NSYNC-1:0] sync1_r;
    logic [NSYNC-1:0] sync2_r;
    logic             otpw_s;
    logic             shut_s;
    logic             erract_s;
    logic             uv_s;
    logic             pdn_s;
    logic             enn_s;
    logic [1:0]       res_s;

    // two flops per asynchronous level, first stage read only by the second
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= {RESOLUTION_PIN_B, RESOLUTION_PIN_A, ENABLE_LOW_PIN, PDN_PIN,
                        PUMP_UNDERVOLTAGE, DRV_ERR_ACTIVE, OT_PREWARN};
            sync2_r <= sync1_r;
        end
    end

    assign otpw_s   = sync2_r[0];
    assign erract_s = sync2_r[1];
    assign uv_s     = sync2_r[2];
    assign pdn_s    = sync2_r[3];
    assign enn_s    = sync2_r[4];
    assign res_s    = sync2_r[6:5];

    // shutdown is a brief event from the analog side: catch it with its own pair
    logic shut1_r;
    logic shut2_r;
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            shut1_r <= 1'b0;
            shut2_r <= 1'b0;
        end else begin
            shut1_r <= DRV_SHUTDOWN;
            shut2_r <= shut1_r;
        end
    end
    assign shut_s = shut2_r;

    // ------------------------------------------------------------
    // frame decode
    // ------------------------------------------------------------
    logic       is_write;
    logic       is_read;
    logic [6:0] reg_addr;

    // bit 7 of the address byte marks a write
    assign is_write = FRAME_VALID & FRAME_REQ.addr[`DGC_WRITE_BIT];  // RULE15
    assign is_read  = FRAME_VALID & ~FRAME_REQ.addr[`DGC_WRITE_BIT]; // RULE15
    assign reg_addr = FRAME_REQ.addr[6:0];

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [`DGC_GLOBAL_CONFIGURATION_W-1:0]  global_configuration_r;
    logic [`DGC_GLOBAL_CONFIGURATION_W-1:0]  global_configuration_nxt;
    logic [1:0]               gflags_r;   // reset and driver error, sticky
    logic [1:0]               gflags_nxt;
    logic [`DGC_WCOUNT_W-1:0] wcount_r;
    logic [`DGC_WCOUNT_W-1:0] wcount_nxt;
    logic [`DGC_DELAY_W-1:0]  delay_r;
    logic [`DGC_DELAY_W-1:0]  delay_nxt;
    logic                     step_tgl_r;
    logic                     step_tgl_nxt;

    // writes, flag set/clear, counter and marker toggle
    always_comb begin
        global_configuration_nxt    = global_configuration_r;
        gflags_nxt   = gflags_r;
        wcount_nxt   = wcount_r;
        delay_nxt    = delay_r;
        step_tgl_nxt = step_tgl_r ^ STEP_EVENT; // RULE2
        if (is_write) begin
            wcount_nxt = wcount_r + 8'h01; // RULE12 RULE13
            case (reg_addr)
                `DGC_ADDR_GLOBAL_CONFIGURATION: begin
                    global_configuration_nxt = FRAME_REQ.data[`DGC_GLOBAL_CONFIGURATION_W-1:0]; // RULE18
                end
                `DGC_ADDR_GFLAGS: begin
                    if (FRAME_REQ.data[`DGC_GF_RESET]) begin
                        gflags_nxt[`DGC_GF_RESET] = 1'b0; // RULE8 RULE9
                    end
                    if (FRAME_REQ.data[`DGC_GF_DRV] && !erract_s) begin
                        gflags_nxt[`DGC_GF_DRV] = 1'b0; // RULE8 RULE10
                    end
                end
                `DGC_ADDR_REPLYCFG: begin
                    delay_nxt = FRAME_REQ.data[11:8]; // RULE14
                end
                default: ;
            endcase
        end
        // a new shutdown in the clearing cycle wins over the clear
        if (shut_s) begin
            gflags_nxt[`DGC_GF_DRV] = 1'b1; // RULE10
        end
    end

    // register bank flops; reset flag comes up set
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            global_configuration_r    <= `DGC_GLOBAL_CONFIGURATION_RST;  // RULE6 RULE16
            gflags_r   <= `DGC_GFLAGS_RST; // RULE9
            wcount_r   <= `DGC_WCOUNT_RST; // RULE16
            delay_r    <= `DGC_DELAY_RST;
            step_tgl_r <= 1'b0;
        end else begin
            global_configuration_r    <= global_configuration_nxt;
            gflags_r   <= gflags_nxt;
            wcount_r   <= wcount_nxt;
            delay_r    <= delay_nxt;
            step_tgl_r <= step_tgl_nxt;
        end
    end

    // ------------------------------------------------------------
    // read reply
    // ------------------------------------------------------------
    dgc_reply_t rd_r;
    dgc_reply_t rd_nxt;
    logic       rvalid_r;
    logic       timer_done;

    // capture the read data when the request arrives; unmapped reads zero
    always_comb begin
        rd_nxt = rd_r;
        if (is_read) begin
            rd_nxt.addr = FRAME_REQ.addr;
            case (reg_addr)
                `DGC_ADDR_GLOBAL_CONFIGURATION:  rd_nxt.data = {22'h0, global_configuration_r};
                `DGC_ADDR_GFLAGS: rd_nxt.data = {29'h0, uv_s, gflags_r}; // RULE11
                `DGC_ADDR_WCOUNT: rd_nxt.data = {24'h0, wcount_r};
                default:          rd_nxt.data = 32'h0; // RULE18
            endcase
        end
    end

    dgc_reply_timer u_timer (
        .clk      (SYS_CLK),
        .rst      (RST),
        .start    (is_read),
        .delay    (delay_r),
        .bit_tick (BIT_TICK),
        .done     (timer_done)
    );

    // reply register and release pulse
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            rd_r     <= '0;
            rvalid_r <= 1'b0;
        end else begin
            rd_r     <= rd_nxt;
            rvalid_r <= timer_done; // RULE14
        end
    end

    // ------------------------------------------------------------
    // driver control outputs
    // ------------------------------------------------------------
    logic [11:0] ctl_r;
    logic [11:0] ctl_nxt;
    logic        marker;

    // marker source: step toggle, prewarning or first microstep position
    always_comb begin
        if (global_configuration_r[`DGC_GC_MARK_STEP]) begin
            marker = step_tgl_r; // RULE2
        end else if (global_configuration_r[`DGC_GC_MARK_PREWARN]) begin
            marker = otpw_s; // RULE1
        end else begin
            marker = MSTEP_FIRST_POS; // RULE17
        end
        ctl_nxt[0]    = marker;
        ctl_nxt[1]    = ~global_configuration_r[`DGC_GC_PD_DISABLE] & pdn_s; // RULE3
        ctl_nxt[2]    = global_configuration_r[`DGC_GC_MSTEP_REG]; // RULE5
        ctl_nxt[4:3]  = res_s; // RULE5
        ctl_nxt[5]    = global_configuration_r[`DGC_GC_STEP_FILT]; // RULE6
        ctl_nxt[6]    = global_configuration_r[`DGC_GC_TEST_MODE]; // RULE7
        ctl_nxt[7]    = (global_configuration_r[`DGC_GC_TEST_MODE] | ~enn_s) & ~uv_s; // RULE7 RULE11
        ctl_nxt[11:8] = global_configuration_r[3:0];
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            ctl_r <= '0;
        end else begin
            ctl_r <= ctl_nxt;
        end
    end

    assign INDEX_OUT           = ctl_r[0];
    assign STANDSTILL_REDUCE   = ctl_r[1];
    assign MSTEP_FROM_REG      = ctl_r[2];
    assign RES_PINS            = ctl_r[4:3];
    assign STEP_FILTER_EN      = ctl_r[5];
    assign TEST_PROBE_EN       = ctl_r[6];
    assign ENABLE_PULLDOWN_OFF = ctl_r[6];
    assign DRIVER_ENABLE       = ctl_r[7];
    assign GLOBAL_CONFIGURATION_LOW           = ctl_r[11:8];
    assign REPLY_VALID         = rvalid_r;
    assign REPLY               = rd_r;

endmodule // dgc_regs

// ===== sim/dgc_host.sv
// host model: issues serial frames and bit ticks toward the register bank
`timescale 1ns/1ps
module dgc_host (
    input  wire logic                clk,
    input  wire logic                reply_valid,
    input  wire dgc_pkg::dgc_reply_t reply,
    output dgc_pkg::dgc_req_t        frame_req,
    output logic                     frame_valid,
    output logic                     bit_tick
);
    import dgc_pkg::*;
    // ------------------------------------------------------------
    // bit timing and frame tasks
    // ------------------------------------------------------------
    logic [1:0] div_r = 2'h0;
    initial begin
        frame_valid = 1'b0;
        frame_req = '0;
        bit_tick = 1'b0;
    end
    // one bit time every four clocks
    always @(negedge clk) begin
        div_r <= div_r + 2'h1;
        bit_tick <= (div_r == 2'h3);
    end
    // one frame, then the bus goes to a changed pattern
    task automatic send(input logic [7:0] a, input logic [31:0] d);
        @(negedge clk);
        frame_valid = 1'b1;
        frame_req = {a, d};
        @(negedge clk);
        frame_valid = 1'b0;
        frame_req = ~frame_req;
    endtask
    task automatic wr(input logic [6:0] a, input logic [31:0] d);
        send({1'b1, a}, d);
    endtask
    // read aligned one clock after a tick; counts ticks until the reply
    task automatic rd(input logic [6:0] a, output logic [31:0] d, output int n);
        n = 0;
        do @(posedge clk); while (bit_tick !== 1'b1);
        send({1'b0, a}, 32'h0);
        repeat (2000) begin
            @(posedge clk);
            #1;
            n += int'(bit_tick);
            if (reply_valid === 1'b1) break;
        end
        if (reply_valid !== 1'b1) n = -1; // no reply within the limit
        d = reply.data;
    endtask
endmodule // dgc_host

// ===== sim/dgc_regs_sva.sv
// checker for the general configuration register bank
`timescale 1ns/1ps
module dgc_regs_sva (
    input wire logic              SYS_CLK,
    input wire logic              RST,
    input wire logic              FRAME_VALID,
    input wire dgc_pkg::dgc_req_t FRAME_REQ,
    input wire logic              STEP_EVENT,
    input wire logic              MSTEP_FIRST_POS,
    input wire logic              OT_PREWARN,
    input wire logic              PUMP_UNDERVOLTAGE,
    input wire logic              PDN_PIN,
    input wire logic              ENABLE_LOW_PIN,
    input wire logic              RESOLUTION_PIN_A,
    input wire logic              RESOLUTION_PIN_B,
    input wire logic              INDEX_OUT,
    input wire logic              STANDSTILL_REDUCE,
    input wire logic              MSTEP_FROM_REG,
    input wire logic [1:0]        RES_PINS,
    input wire logic              STEP_FILTER_EN,
    input wire logic              TEST_PROBE_EN,
    input wire logic              ENABLE_PULLDOWN_OFF,
    input wire logic              DRIVER_ENABLE,
    input wire logic [3:0]        GLOBAL_CONFIGURATION_LOW,
    input wire logic              REPLY_VALID
);
    import dgc_pkg::*;
    // ------------------------------------------------------------
    // shadow of the configuration word and properties
    // ------------------------------------------------------------
    logic [9:0] gc_r;
    logic [9:0] gc_nxt;
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    // follow configuration writes seen on the frame port
    always_comb gc_nxt = (FRAME_VALID && FRAME_REQ.addr == 8'h80) ? FRAME_REQ.data[9:0] : gc_r;
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) gc_r <= 10'h101;
        else gc_r <= gc_nxt;
    end
    step_toggle_a: assert property (
        STEP_EVENT && gc_r[5] && $stable(gc_r) |=> ##[0:1] $changed(INDEX_OUT))
        else $error("marker did not toggle on step");
    prewarn_mark_a: assert property (
        (!gc_r[5] && gc_r[4] && $stable(OT_PREWARN) && $stable(gc_r)) [*6]
        |-> INDEX_OUT == OT_PREWARN) else $error("marker not showing prewarning");
    first_pos_a: assert property (
        (gc_r[5:4] == 2'h0 && $stable(MSTEP_FIRST_POS) && $stable(gc_r)) [*4]
        |-> INDEX_OUT == MSTEP_FIRST_POS) else $error("marker not showing first position");
    standstill_a: assert property (
        ($stable(PDN_PIN) && $stable(gc_r)) [*6]
        |-> STANDSTILL_REDUCE == (PDN_PIN & !gc_r[6])) else $error("standstill control wrong");
    cfg_out_a: assert property (
        $stable(gc_r) [*3] |-> MSTEP_FROM_REG == gc_r[7] && STEP_FILTER_EN == gc_r[8]
        && TEST_PROBE_EN == gc_r[9] && ENABLE_PULLDOWN_OFF == gc_r[9] && GLOBAL_CONFIGURATION_LOW == gc_r[3:0])
        else $error("configuration outputs wrong");
    driver_en_a: assert property (
        ($stable(PUMP_UNDERVOLTAGE) && $stable(ENABLE_LOW_PIN) && $stable(gc_r)) [*6]
        |-> DRIVER_ENABLE == ((gc_r[9] | !ENABLE_LOW_PIN) & !PUMP_UNDERVOLTAGE))
        else $error("driver enable wrong");
    reply_pulse_a: assert property (
        REPLY_VALID |=> !REPLY_VALID) else $error("reply strobe longer than one cycle");
    res_pins_a: assert property (
        $stable({RESOLUTION_PIN_B, RESOLUTION_PIN_A}) [*5]
        |-> RES_PINS == {RESOLUTION_PIN_B, RESOLUTION_PIN_A}) else $error("resolution pins wrong");
    cover property (REPLY_VALID);
    cover property (STEP_EVENT && gc_r[5]);
    cover property (PUMP_UNDERVOLTAGE && !DRIVER_ENABLE);
endmodule // dgc_regs_sva

bind dgc_regs dgc_regs_sva i_sva (.*);

// ===== sim/tb.sv
// testbench for the general configuration register bank
`timescale 1ns/1ps
module tb;
    import dgc_pkg::*;
    // ------------------------------------------------------------
    // signals, instances, checking tasks
    // ------------------------------------------------------------
    logic SYS_CLK = 1'b0;
    logic RST = 1'b1;
    logic FRAME_VALID, BIT_TICK, INDEX_OUT, STANDSTILL_REDUCE, MSTEP_FROM_REG;
    logic STEP_FILTER_EN, TEST_PROBE_EN, ENABLE_PULLDOWN_OFF, DRIVER_ENABLE, REPLY_VALID;
    logic STEP_EVENT = 1'b0, MSTEP_FIRST_POS = 1'b0, OT_PREWARN = 1'b0, DRV_SHUTDOWN = 1'b0;
    logic DRV_ERR_ACTIVE = 1'b0, PUMP_UNDERVOLTAGE = 1'b0, PDN_PIN = 1'b0;
    logic ENABLE_LOW_PIN = 1'b0, RESOLUTION_PIN_A = 1'b0, RESOLUTION_PIN_B = 1'b0;
    logic [1:0]  RES_PINS;
    logic [3:0]  GLOBAL_CONFIGURATION_LOW;
    dgc_req_t    FRAME_REQ;
    dgc_reply_t  REPLY;
    logic [7:0]  wcnt = 8'h00;
    logic [31:0] got, v;
    int          miscompares = 0, comparisons = 0, n;
    int          seed = 32'hbe0ec3c2;
    always #5 SYS_CLK = ~SYS_CLK;
    dgc_regs i_dut (.*);
    dgc_host i_host (.clk(SYS_CLK), .reply_valid(REPLY_VALID), .reply(REPLY),
                     .frame_req(FRAME_REQ), .frame_valid(FRAME_VALID), .bit_tick(BIT_TICK));
    function automatic logic [31:0] reply_ticks(input logic [3:0] d);
        return 32'd8 * (32'd2 * {29'h0, d[3:1]} + 32'd1);
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic tally_and_finish();
        if (miscompares == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic wr(input logic [6:0] a, input logic [31:0] d);
        i_host.wr(a, d);
        wcnt++;
    endtask
    task automatic rdc(input logic [6:0] a, input logic [31:0] e);
        i_host.rd(a, got, n);
        chk(got, e);
        chk(n, 32'd8);
        chk({24'h0, REPLY.addr}, {25'h0, a});
    endtask
    // new random pin levels, then random step pulses
    task automatic wiggle();
        @(negedge SYS_CLK);
        v = $random(seed);
        {MSTEP_FIRST_POS, OT_PREWARN, PDN_PIN, ENABLE_LOW_PIN} = v[3:0];
        {RESOLUTION_PIN_B, RESOLUTION_PIN_A} = v[5:4];
        repeat (20) begin
            @(negedge SYS_CLK);
            v = $random(seed);
            STEP_EVENT = v[0];
        end
        @(negedge SYS_CLK);
        STEP_EVENT = 1'b0;
    endtask
    task automatic waitn(input int k);
        repeat (k) @(negedge SYS_CLK);
    endtask
    // hang guard
    initial begin
        #600000;
        miscompares++;
        tally_and_finish();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        waitn(5);
        RST = 1'b0;
        rdc(7'h01, 32'h1);
        rdc(7'h00, 32'h101);
        rdc(7'h02, 32'h0);
        chk({31'h0, STEP_FILTER_EN}, 32'h1);
        wr(7'h00, 32'hffffffff);
        rdc(7'h00, 32'h3ff);
        wiggle();
        repeat (6) begin
            v = $random(seed) & 32'h1ff;
            wr(7'h00, v);
            rdc(7'h00, v);
            chk({24'h0, MSTEP_FROM_REG, STEP_FILTER_EN, TEST_PROBE_EN, ENABLE_PULLDOWN_OFF,
                 GLOBAL_CONFIGURATION_LOW}, {24'h0, v[7], v[8], v[9], v[9], v[3:0]});
            wiggle();
        end
        wr(7'h00, 32'h30);
        wiggle();
        wr(7'h00, 32'h10);
        wiggle();
        wr(7'h00, 32'h140);
        wiggle();
        chk({31'h0, STANDSTILL_REDUCE}, 32'h0);
        for (int d = 0; d < 16; d++) begin
            wr(7'h03, {20'h0, d[3:0], 8'h0});
            i_host.rd(7'h02, got, n);
            chk(got, {24'h0, wcnt});
            chk(n, reply_ticks(d[3:0]));
        end
        wr(7'h03, 32'h0);
        rdc(7'h03, 32'h0);
        rdc(7'h15, 32'h0);
        waitn(1);
        DRV_SHUTDOWN = 1'b1;
        DRV_ERR_ACTIVE = 1'b1;
        waitn(3);
        DRV_SHUTDOWN = 1'b0;
        wr(7'h01, 32'h2);
        rdc(7'h01, 32'h3);
        waitn(1);
        DRV_ERR_ACTIVE = 1'b0;
        waitn(4);
        wr(7'h01, 32'h1);
        rdc(7'h01, 32'h2);
        wr(7'h01, 32'h2);
        rdc(7'h01, 32'h0);
        waitn(1);
        PUMP_UNDERVOLTAGE = 1'b1;
        waitn(8);
        chk({31'h0, DRIVER_ENABLE}, 32'h0);
        wr(7'h01, 32'h7);
        rdc(7'h01, 32'h4);
        waitn(1);
        PUMP_UNDERVOLTAGE = 1'b0;
        waitn(8);
        rdc(7'h01, 32'h0);
        repeat (300) wr(7'h02, $random(seed));
        rdc(7'h02, {24'h0, wcnt});
        waitn(1);
        RST = 1'b1;
        waitn(2);
        RST = 1'b0;
        wcnt = 8'h00;
        rdc(7'h01, 32'h1);
        rdc(7'h02, 32'h0);
        rdc(7'h00, 32'h101);
        tally_and_finish();
    end
endmodule // tb
